// ==== sfb_core.sv ====
// Function
// [RL1] bit-store copies register bit into transfer flag
// [RL2] bit-load writes transfer flag into register bit
// [RL3] clear-half-carry forces half-carry flag to zero
// [RL4] clear-overflow forces overflow flag to zero
// [RL5] clear-sign forces sign flag to zero
// [RL6] post-inc load reads pointer byte, increments pointer unless a pointer preset lands in the same cycle
// [RL7] flag ops touch only their own flag
`timescale 1ns/1ns
`include "sfb_map.svh"
module sfb_core (
   // clock and reset
   input  wire logic                sys_clk,
   input  wire logic                reset_n,
   // instruction in
   input  wire logic                instr_valid,
   input  wire sfb_pkg::sfb_instr_s instr,
   // pointer preset
   input  wire logic                ptr_load,
   input  wire logic [15:0]         ptr_load_val,
   // data memory read, data taken in the same cycle the request is valid
   output sfb_pkg::sfb_memreq_s     mem_req,
   input  wire logic [7:0]          mem_rdata,
   // state
   output logic [7:0]               status_flags_register,
   output logic [7:0]               reg_file_view,
   output logic [15:0]              ptr_out,
   output logic                     busy
);
   // all checks run on the core clock and rest while in reset
   default clocking cb_core @(posedge sys_clk);
   endclocking
   default disable iff (!reset_n);

   // working registers
   logic [7:0] regs [`SFB_NREGS];
   // pending load destination
   logic [4:0] ld_dst;
   // pointer value
   wire logic [15:0] ptr;

   // decoded strobes
   wire logic do_bst;
   wire logic do_bld;
   wire logic do_clh;
   wire logic do_clv;
   wire logic do_cls;
   wire logic do_ldpi;
   assign do_bst  = instr_valid && !busy
                    && instr.op == sfb_pkg::SFB_OP_BST;
   assign do_bld  = instr_valid && !busy
                    && instr.op == sfb_pkg::SFB_OP_BLD;
   assign do_clh  = instr_valid && !busy
                    && instr.op == sfb_pkg::SFB_OP_CLH;
   assign do_clv  = instr_valid && !busy
                    && instr.op == sfb_pkg::SFB_OP_CLV;
   assign do_cls  = instr_valid && !busy
                    && instr.op == sfb_pkg::SFB_OP_CLS;
   assign do_ldpi = instr_valid && !busy
                    && instr.op == sfb_pkg::SFB_OP_LDPI;

   // selected source bit and transfer flag
   wire logic src_bit;
   wire logic tflag;
   assign src_bit = regs[instr.reg_a][instr.bsel];
   assign tflag   = status_flags_register[`SFB_FLAG_T];

   // next status flags, each op touches its own bit only
   logic [7:0] next_flags;
   always_comb begin
      next_flags = status_flags_register;
      if (do_bst) begin
         next_flags[`SFB_FLAG_T] = src_bit; // see [RL1] see [RL7]
      end else if (do_clh) begin
         next_flags[`SFB_FLAG_H] = 1'b0; // see [RL3] see [RL7]
      end else if (do_clv) begin
         next_flags[`SFB_FLAG_V] = 1'b0; // see [RL4] see [RL7]
      end else if (do_cls) begin
         next_flags[`SFB_FLAG_S] = 1'b0; // see [RL5] see [RL7]
      end
   end

   // flag bit that the accepted op is allowed to change
   wire logic [7:0] flag_mask;
   assign flag_mask = do_bst ? 8'h01 << `SFB_FLAG_T
                    : do_clh ? 8'h01 << `SFB_FLAG_H
                    : do_clv ? 8'h01 << `SFB_FLAG_V
                    : do_cls ? 8'h01 << `SFB_FLAG_S
                    : '0;

   // bit-load may flip only the selected bit, toward the flag
   wire logic [7:0] bld_diff;
   assign bld_diff = {7'h00, tflag ^ src_bit} << instr.bsel;

   // bit-load result for destination
   logic [7:0] bld_val;
   always_comb begin
      bld_val = regs[instr.reg_a];
      bld_val[instr.bsel] = tflag; // see [RL2]
   end

   // status flags
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         status_flags_register <= `SFB_FLAGS_RST;
      end else begin
         status_flags_register <= next_flags;
      end
   end

   // working registers, one per generate slice
   genvar gi;
   generate
      for (gi = 0; gi < `SFB_NREGS; gi++) begin : g_reg
         always_ff @(posedge sys_clk or negedge reset_n) begin
            if (!reset_n) begin
               regs[gi] <= `SFB_REG_RST;
            end else if (busy && ld_dst == 5'(gi)) begin
               regs[gi] <= mem_rdata; // see [RL6]
            end else if (do_bld && instr.reg_a == 5'(gi)) begin
               regs[gi] <= bld_val; // see [RL2]
            end
         end
      end
   endgenerate

   // load sequencing: request, then capture data
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         busy    <= 1'b0;
         ld_dst  <= '0;
         mem_req <= '0;
      end else begin
         busy          <= do_ldpi;
         mem_req.valid <= do_ldpi;
         if (do_ldpi) begin
            ld_dst       <= instr.reg_a;
            mem_req.addr <= ptr; // see [RL6]
         end
      end
   end

   // pointer unit
   sfb_ptr_unit u_ptr (
      .sys_clk  (sys_clk),
      .reset_n  (reset_n),
      .load     (ptr_load),
      .load_val (ptr_load_val),
      .incr     (do_ldpi),
      .ptr      (ptr)
   );

   // registered views
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         ptr_out       <= `SFB_PTR_RST;
         reg_file_view <= `SFB_REG_RST;
      end else begin
         ptr_out       <= ptr;
         reg_file_view <= regs[instr.reg_a];
      end
   end

   // checks
   // bit-store: transfer flag takes the addressed bit
   a_bst_copy: assert property (do_bst |=> // see [RL1]
      status_flags_register[`SFB_FLAG_T] == $past(src_bit))
      else $error("bit store wrong");
   // bit-load: only the addressed bit may move
   a_bld_bit: assert property (do_bld |=> // see [RL2]
      (regs[$past(instr.reg_a)] ^ $past(regs[instr.reg_a]))
      == $past(bld_diff))
      else $error("bit load wrong");
   // bit-load: the addressed bit ends as the old flag
   a_bld_flag: assert property (do_bld |=> // see [RL2]
      regs[$past(instr.reg_a)][$past(instr.bsel)] == $past(tflag))
      else $error("bit load lost flag");
   // clears force their flag low
   a_clh_zero: assert property (do_clh |=> // see [RL3]
      !status_flags_register[`SFB_FLAG_H])
      else $error("half carry not cleared");
   a_clv_zero: assert property (do_clv |=> // see [RL4]
      !status_flags_register[`SFB_FLAG_V])
      else $error("overflow not cleared");
   a_cls_zero: assert property (do_cls |=> // see [RL5]
      !status_flags_register[`SFB_FLAG_S])
      else $error("sign not cleared");
   // load accepted with no pointer preset in the same cycle
   sequence s_ld_issue;
      do_ldpi && !ptr_load;
   endsequence
   // load accepted, then its data cycle
   sequence s_ld_data;
      do_ldpi ##1 busy;
   endsequence
   // pointer steps once per accepted load with no pointer preset in the same cycle
   a_ldpi_inc: assert property (s_ld_issue |=> // see [RL6]
      ptr == $past(ptr) + `SFB_PTR_STEP)
      else $error("pointer not incremented");
   // request carries the pointer value before its step
   a_ldpi_req: assert property (do_ldpi |=> // see [RL6]
      mem_req.valid && mem_req.addr == $past(ptr))
      else $error("load address wrong");
   // byte lands in the destination at the data cycle
   a_ldpi_data: assert property (s_ld_data |=> // see [RL6]
      regs[$past(ld_dst)] == $past(mem_rdata))
      else $error("load data wrong");
   // request is a single pulse, and busy is low in the cycle after it
   a_req_pulse: assert property (mem_req.valid |=> // see [RL6]
      !mem_req.valid && !busy)
      else $error("load request held too long");
   // an instruction offered while busy leaves the flags alone
   a_busy_drop: assert property (busy |=> // see [RL6]
      status_flags_register == $past(status_flags_register))
      else $error("instruction taken while busy");
   // flag ops change no flag but their own
   a_flag_only: assert property ( // see [RL7]
      (do_bst || do_clh || do_clv || do_cls) |=>
      ((status_flags_register ^ $past(status_flags_register))
       & ~$past(flag_mask)) == '0)
      else $error("other flag changed");
   // flag ops leave the addressed working register alone
   a_flag_regs: assert property ( // see [RL7]
      (do_bst || do_clh || do_clv || do_cls) |=>
      regs[$past(instr.reg_a)] == $past(regs[instr.reg_a]))
      else $error("register changed by flag op");
endmodule : sfb_core

// ==== sfb_map.svh ====
`ifndef SFB_MAP_SVH
`define SFB_MAP_SVH
// status flag bit positions
`define SFB_FLAG_C      3'h0
`define SFB_FLAG_Z      3'h1
`define SFB_FLAG_N      3'h2
`define SFB_FLAG_V      3'h3
`define SFB_FLAG_S      3'h4
`define SFB_FLAG_H      3'h5
`define SFB_FLAG_T      3'h6
`define SFB_FLAG_I      3'h7
// reset values
`define SFB_FLAGS_RST   8'h00
`define SFB_REG_RST     8'h00
`define SFB_PTR_RST     16'h0000
// pointer step
`define SFB_PTR_STEP    16'h0001
// working register count
`define SFB_NREGS       32
`endif

// ==== sfb_pkg.sv ====
package sfb_pkg;
   // operations executed by the block
   typedef enum logic [2:0] {
      SFB_OP_NOP  = 3'b000,
      SFB_OP_BST  = 3'b001,
      SFB_OP_BLD  = 3'b010,
      SFB_OP_CLH  = 3'b011,
      SFB_OP_CLV  = 3'b100,
      SFB_OP_CLS  = 3'b101,
      SFB_OP_LDPI = 3'b110
   } sfb_op_e;

   // one decoded instruction
   typedef struct packed {
      sfb_op_e    op;    // operation
      logic [4:0] reg_a; // source or destination register
      logic [2:0] bsel;  // bit position
   } sfb_instr_s;

   // memory read request
   typedef struct packed {
      logic        valid; // request present
      logic [15:0] addr;  // byte address
   } sfb_memreq_s;
endpackage : sfb_pkg

// ==== sfb_ptr_unit.sv ====
`timescale 1ns/1ns
`include "sfb_map.svh"
// pointer register pair with post-increment
module sfb_ptr_unit (
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        reset_n,
   // control
   input  wire logic        load,
   input  wire logic [15:0] load_val,
   input  wire logic        incr,
   // state
   output logic [15:0]      ptr
);
   // incremented value
   wire logic [15:0] ptr_inc;
   assign ptr_inc = ptr + `SFB_PTR_STEP;

   // load wins over increment
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         ptr <= `SFB_PTR_RST;
      end else if (load) begin
         ptr <= load_val;
      end else if (incr) begin
         ptr <= ptr_inc; // see [RL6]
      end
   end
endmodule : sfb_ptr_unit

// ==== tb_status_flag_bit_instructions.sv ====
`timescale 1ns/1ns
module tb_status_flag_bit_instructions;
   // stimulus, all driven 1 ns after the rising edge
   logic                 sys_clk = 1'b0;
   logic                 reset_n = 1'b0;
   logic                 instr_valid = 1'b0;
   sfb_pkg::sfb_instr_s  instr = '0;
   logic                 ptr_load = 1'b0;
   logic [15:0]          ptr_load_val = 16'h0000;
   logic [7:0]           mem_rdata = 8'h00;
   // observed outputs
   sfb_pkg::sfb_memreq_s mem_req;
   logic [7:0]           status_flags_register;
   logic [7:0]           reg_file_view;
   logic [15:0]          ptr_out;
   logic                 busy;
   // scoreboard
   int                   error_cnt = 0;
   int                   compares = 0;

   // 50 MHz clock
   always #10 sys_clk = ~sys_clk;

   sfb_core u_dut (
      .sys_clk(sys_clk), .reset_n(reset_n), .instr_valid(instr_valid),
      .instr(instr), .ptr_load(ptr_load), .ptr_load_val(ptr_load_val),
      .mem_req(mem_req), .mem_rdata(mem_rdata),
      .status_flags_register(status_flags_register),
      .reg_file_view(reg_file_view), .ptr_out(ptr_out), .busy(busy)
   );

   // compare seen against expected
   task check(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // verdict and end of run
   task finish_test;
      if (error_cnt == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : finish_test

   // one instruction; returns just after its taking edge settled
   task issue(input sfb_pkg::sfb_op_e op, input logic [4:0] ra,
              input logic [2:0] b);
      @(posedge sys_clk) #1;
      instr_valid = 1'b1;
      instr = '{op, ra, b};
      @(posedge sys_clk) #1;
      instr_valid = 1'b0;
      instr.op = sfb_pkg::SFB_OP_NOP;
   endtask : issue

   // register view lags the selected index by one edge
   task view(input logic [4:0] ra, input logic [7:0] exp);
      instr.reg_a = ra;
      repeat (2) @(posedge sys_clk);
      #1;
      check(reg_file_view, exp);
   endtask : view

   // preset across a byte carry, then two indirect loads
   task test_load;
      @(posedge sys_clk) #1;
      ptr_load = 1'b1;
      ptr_load_val = 16'h12ff;
      @(posedge sys_clk) #1;
      ptr_load = 1'b0;
      for (int i = 0; i < 2; i++) begin
         mem_rdata = 8'ha5 ^ 8'(i);
         issue(sfb_pkg::SFB_OP_LDPI, 5'(3 + i), 3'h0);
         check({mem_req.valid, busy}, 2'b11);
         check(mem_req.addr, 16'(16'h12ff + i));
         view(5'(3 + i), 8'ha5 ^ 8'(i));
         check(ptr_out, 16'(16'h1300 + i));
         mem_rdata = 8'h3c;
      end
   endtask : test_load

   // transfer flag from every bit of a known register, then into bit 1 of register 4
   task test_bits;
      logic [7:0] v;
      v = 8'ha5;
      for (int b = 0; b < 8; b++) begin
         issue(sfb_pkg::SFB_OP_BST, 5'h03, 3'(b));
         check(status_flags_register, {1'b0, v[b], 6'h00});
      end
      issue(sfb_pkg::SFB_OP_BLD, 5'h04, 3'h1);
      view(5'h04, 8'ha6);
      check(status_flags_register, 8'h40);
   endtask : test_bits

   // clears leave the set transfer flag alone
   task test_clear;
      issue(sfb_pkg::SFB_OP_CLH, 5'h03, 3'h0);
      check(status_flags_register, 8'h40);
      issue(sfb_pkg::SFB_OP_CLV, 5'h03, 3'h0);
      check(status_flags_register, 8'h40);
      issue(sfb_pkg::SFB_OP_CLS, 5'h03, 3'h0);
      check(status_flags_register, 8'h40);
      view(5'h03, 8'ha5);
   endtask : test_clear

   // a bit-store offered in the dead cycle after a load is dropped
   task test_refuse;
      mem_rdata = 8'h5a;
      @(posedge sys_clk) #1;
      instr_valid = 1'b1;
      instr = '{sfb_pkg::SFB_OP_LDPI, 5'h05, 3'h0};
      @(posedge sys_clk) #1;
      instr = '{sfb_pkg::SFB_OP_BST, 5'h04, 3'h0};
      @(posedge sys_clk) #1;
      instr_valid = 1'b0;
      instr.op = sfb_pkg::SFB_OP_NOP;
      check(status_flags_register, 8'h40);
      view(5'h05, 8'h5a);
      check(ptr_out, 16'h1302);
   endtask : test_refuse

   // main sequence
   initial begin
      repeat (8) @(posedge sys_clk);
      #1;
      reset_n = 1'b1;
      check(status_flags_register, 8'h00);
      test_load;
      test_bits;
      test_clear;
      test_refuse;
      finish_test;
   end

   // watchdog
   initial begin
      #20000;
      error_cnt++;
      finish_test;
   end
endmodule : tb_status_flag_bit_instructions
